// file: core/dcw_consts.svh
`ifndef DCW_CONSTS_SVH
`define DCW_CONSTS_SVH

// byte offsets of the register words
`define DCW_OFS_SRC_END   4'h0
`define DCW_OFS_DST_END   4'h4
`define DCW_OFS_CTL       4'h8
`define DCW_OFS_RUN       4'hC

// control word fields
`define DCW_DST_STEP      31:30
`define DCW_DST_WIDTH     29:28
`define DCW_SRC_STEP      27:26
`define DCW_SRC_WIDTH     25:24
`define DCW_ARB_COUNT     17:14
`define DCW_ITEM_COUNT    13:4
`define DCW_NEXT_BURST    3
`define DCW_KIND          2:0
`define DCW_CTL_WMASK     32'hFF03_FFFF
`define DCW_CTL_RESET     32'h0000_0000
`define DCW_PTR_RESET     32'h0000_0000

// step code that pins an address to its end pointer
`define DCW_STEP_FIXED    2'h3

// run register: write bit 0 starts; read busy, done, remaining
`define DCW_RUN_GO        0
`define DCW_RUN_BUSY      0
`define DCW_RUN_DONE      1
`define DCW_RUN_REMAIN    25:16

`endif

// file: core/dcw_pkg.sv
package dcw_pkg;

    typedef enum logic [1:0] {
        DCW_IDLE = 2'b01,
        DCW_RUN  = 2'b10
    } dcw_state_t;

    typedef struct packed {
        dcw_state_t  state;
        logic [31:0] src_end;
        logic [31:0] dst_end;
        logic [31:0] ctl;
        logic [9:0]  remain;
        logic        done;
        logic        ack;
        logic [31:0] rdata;
    } dcw_regs_t;

endpackage

// file: core/dcw_fifo.sv
`timescale 1ns/1ps

module dcw_fifo #(
    parameter int WIDTH = 66,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_r != (PW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr_r];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr_r] <= in_data_i;
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule // dcw_fifo

// file: core/dcw_top.sv
// Contract
// - destination step code: byte, half, word, fixed
// - fixed destination stays at its end pointer
// - destination width codes mean 8, 16, 32 bits; the code stores the field but item_width_o carries only the source width
// - source step code decoded the same way
// - fixed source reads only its end pointer
// - control word resets zero, reserved bits read zero
// - end pointers are last address, inclusive
// - source width codes mean 8, 16, 32 bits
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`include "dcw_consts.svh"

module dcw_top #(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             item_valid_o,
    input  wire logic        item_ready_i,
    output logic [31:0]      item_src_addr_o,
    output logic [31:0]      item_dst_addr_o,
    output logic [1:0]       item_width_o,
    output logic             busy_o
);
    localparam int FW = 66;

    dcw_pkg::dcw_regs_t q_r;
    dcw_pkg::dcw_regs_t q_nxt;
    logic               push_valid;
    logic               push_ready;
    logic [FW-1:0]      push_data;
    logic [FW-1:0]      pop_data;
    logic               wb_req;
    logic [31:0]        src_addr;
    logic [31:0]        dst_addr;

    function automatic logic [31:0] dcw_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                res[b*8 +: 8] = new_v[b*8 +: 8];
        return res;
    endfunction

    // step back from the inclusive end by step size times items left
    function automatic logic [31:0] dcw_item_addr(input logic [31:0] end_ptr,
                                                  input logic [1:0]  step,
                                                  input logic [9:0]  left);
        logic [31:0] ofs;
        ofs = {22'h0, left} << step;
        if (step == `DCW_STEP_FIXED)
            return end_ptr;
        return end_ptr - ofs;
    endfunction

    assign wb_req = wb_cyc_i && wb_stb_i && !q_r.ack;

    // step codes 0..2 shift by 0..2
    assign src_addr = dcw_item_addr(q_r.src_end, q_r.ctl[`DCW_SRC_STEP], q_r.remain);
    assign dst_addr = dcw_item_addr(q_r.dst_end, q_r.ctl[`DCW_DST_STEP], q_r.remain);

    assign push_valid = (q_r.state == dcw_pkg::DCW_RUN);
    assign push_data  = {q_r.ctl[`DCW_SRC_WIDTH], src_addr, dst_addr};

    always_comb
    begin
        q_nxt       = q_r;
        q_nxt.ack   = wb_req;
        q_nxt.rdata = '0;
        unique case (q_r.state)
            dcw_pkg::DCW_IDLE:
            begin
                if (wb_req && wb_we_i && wb_adr_i[3:2] == 2'(`DCW_OFS_RUN >> 2)
                    && wb_sel_i[0] && wb_dat_i[`DCW_RUN_GO])
                begin
                    q_nxt.state  = dcw_pkg::DCW_RUN;
                    q_nxt.remain = q_r.ctl[`DCW_ITEM_COUNT];
                    q_nxt.done   = 1'b0;
                end
            end
            dcw_pkg::DCW_RUN:
            begin
                if (push_ready)
                begin
                    if (q_r.remain == '0)
                    begin
                        q_nxt.state = dcw_pkg::DCW_IDLE;
                        q_nxt.done  = 1'b1;
                    end
                    else
                        q_nxt.remain = q_r.remain - 1'b1;
                end
            end
        endcase
        // settings are frozen while a transfer runs
        if (wb_req && wb_we_i && q_r.state == dcw_pkg::DCW_IDLE)
        begin
            unique case (wb_adr_i[3:2])
                2'(`DCW_OFS_SRC_END >> 2):
                    q_nxt.src_end = dcw_merge(q_r.src_end, wb_dat_i, wb_sel_i);
                2'(`DCW_OFS_DST_END >> 2):
                    q_nxt.dst_end = dcw_merge(q_r.dst_end, wb_dat_i, wb_sel_i);
                2'(`DCW_OFS_CTL >> 2):
                    q_nxt.ctl = dcw_merge(q_r.ctl, wb_dat_i, wb_sel_i) & `DCW_CTL_WMASK;
                default: ;
            endcase
        end
        if (wb_req && !wb_we_i)
        begin
            unique case (wb_adr_i[3:2])
                2'(`DCW_OFS_SRC_END >> 2): q_nxt.rdata = q_r.src_end;
                2'(`DCW_OFS_DST_END >> 2): q_nxt.rdata = q_r.dst_end;
                2'(`DCW_OFS_CTL >> 2):     q_nxt.rdata = q_r.ctl;
                default:
                begin
                    q_nxt.rdata[`DCW_RUN_BUSY]   = (q_r.state == dcw_pkg::DCW_RUN);
                    q_nxt.rdata[`DCW_RUN_DONE]   = q_r.done;
                    q_nxt.rdata[`DCW_RUN_REMAIN] = q_r.remain;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q_r.state   <= dcw_pkg::DCW_IDLE;
            q_r.src_end <= `DCW_PTR_RESET;
            q_r.dst_end <= `DCW_PTR_RESET;
            q_r.ctl     <= `DCW_CTL_RESET;
            q_r.remain  <= '0;
            q_r.done    <= 1'b0;
            q_r.ack     <= 1'b0;
            q_r.rdata   <= '0;
        end
        else
            q_r <= q_nxt;
    end

    dcw_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_data),
        .out_valid_o (item_valid_o),
        .out_ready_i (item_ready_i),
        .out_data_o  (pop_data)
    );

    assign item_width_o    = pop_data[65:64];
    assign item_src_addr_o = pop_data[63:32];
    assign item_dst_addr_o = pop_data[31:0];
    assign wb_dat_o        = q_r.rdata;
    assign wb_ack_o        = q_r.ack;
    assign busy_o          = (q_r.state == dcw_pkg::DCW_RUN);
endmodule // dcw_top

// file: bench/dcw_top_sva.sv
`timescale 1ns/1ps

module dcw_top_sva #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        item_valid_o,
    input wire logic        item_ready_i,
    input wire logic [31:0] item_src_addr_o,
    input wire logic [31:0] item_dst_addr_o,
    input wire logic        busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("stray ack");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
    a_rsvd_zero: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h2 |-> wb_dat_o[23:18] == 6'h0)
        else $error("reserved bits set");
    a_item_hold: assert property (item_valid_o && !item_ready_i |=> item_valid_o
        && $stable(item_src_addr_o) && $stable(item_dst_addr_o)) else $error("item moved");
    a_start_run: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
        && wb_adr_i[3:2] == 2'h3 && wb_sel_i[0] && wb_dat_i[0] && !busy_o
        |=> busy_o ##1 item_valid_o) else $error("no start");
    a_reset_idle: assert property ($fell(rst_i) |-> !busy_o && !item_valid_o && !wb_ack_o)
        else $error("not idle");
endmodule // dcw_top_sva

bind dcw_top dcw_top_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .item_valid_o(item_valid_o),
    .item_ready_i(item_ready_i), .item_src_addr_o(item_src_addr_o),
    .item_dst_addr_o(item_dst_addr_o), .busy_o(busy_o));

// file: bench/dcw_sink.sv
`timescale 1ns/1ps

module dcw_sink (
    input  wire logic        clk_i,
    input  wire logic        stall_i,
    input  wire logic        valid_i,
    input  wire logic [31:0] src_i,
    input  wire logic [31:0] dst_i,
    input  wire logic [1:0]  wid_i,
    output logic             ready_o
);
    logic [31:0] src_q[$];
    logic [31:0] dst_q[$];
    logic [1:0]  wid_q[$];
    initial ready_o = 1'b0;
    // ready lags stall by one cycle, like a registered consumer
    always @(posedge clk_i)
    begin
        if (valid_i === 1'b1 && ready_o === 1'b1)
        begin
            src_q.push_back(src_i);
            dst_q.push_back(dst_i);
            wid_q.push_back(wid_i);
        end
        ready_o <= !stall_i;
    end
endmodule // dcw_sink

// file: bench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic        clk_i = 1'b0, rst_i = 1'b1, stall = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, src_a, dst_a, q;
    logic        wb_ack_o, valid, ready, busy_o;
    logic [1:0]  wid;
    int          error_cnt = 0, samples_checked = 0;
    always #5 clk_i = ~clk_i;

    dcw_top #(.FIFO_DEPTH(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .item_valid_o(valid),
        .item_ready_i(ready), .item_src_addr_o(src_a), .item_dst_addr_o(dst_a),
        .item_width_o(wid), .busy_o(busy_o));
    dcw_sink u_sink (.clk_i(clk_i), .stall_i(stall), .valid_i(valid), .src_i(src_a),
        .dst_i(dst_a), .wid_i(wid), .ready_o(ready));

    task automatic wrap_up;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic hang;
        error_cnt++;
        wrap_up;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 40);
        if (wb_ack_o !== 1'b1)
            hang;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic s_regs;
        for (int a = 0; a < 16; a += 4)
        begin
            wb(1'b0, a[3:0], 32'h0);
            check(q, 32'h0);
        end
        wb(1'b1, 4'h8, 32'hFFFF_FFFF);
        wb_sel_i <= 4'h1;
        wb(1'b1, 4'h8, 32'h0);
        wb_sel_i <= 4'hF;
        wb(1'b0, 4'h8, 32'h0);
        check(q, 32'hFF03_FF00);
    endtask

    task automatic s_move(input logic [1:0] ss, ds, w, input logic [9:0] c);
        logic [31:0] r;
        int n;
        u_sink.src_q.delete();
        u_sink.dst_q.delete();
        u_sink.wid_q.delete();
        wb(1'b1, 4'h0, 32'h0000_1000);
        wb(1'b1, 4'h4, 32'h0000_2000);
        wb(1'b1, 4'h8, {ds, w, ss, w, 10'h0, c, 4'h0});
        wb(1'b1, 4'hC, 32'h1);
        // only long runs are sure to be stalled on a full queue here
        if (c > 10'd4)
        begin
            wb(1'b1, 4'h0, 32'h0000_0BAD);
            wb(1'b0, 4'hC, 32'h0);
            check(q & 32'h03FF_0003, {6'h0, c - 10'd4, 14'h0, 2'h1});
        end
        stall <= 1'b0;
        n = 0;
        while (u_sink.src_q.size() <= c && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 200)
            hang;
        stall <= 1'b1;
        for (int i = 0; i <= c; i++)
        begin
            r = c - i;
            check(u_sink.src_q[i], ss == 2'h3 ? 32'h1000 : 32'h1000 - (r << ss));
            check(u_sink.dst_q[i], ds == 2'h3 ? 32'h2000 : 32'h2000 - (r << ds));
            check({30'h0, u_sink.wid_q[i]}, {30'h0, w});
        end
        wb(1'b0, 4'h0, 32'h0);
        check(q, 32'h1000);
        wb(1'b0, 4'hC, 32'h0);
        check(q & 32'h3, 32'h2);
    endtask

    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        s_regs;
        s_move(2'h0, 2'h0, 2'h0, 10'd5);
        s_move(2'h1, 2'h1, 2'h1, 10'd2);
        s_move(2'h2, 2'h2, 2'h2, 10'd6);
        s_move(2'h3, 2'h2, 2'h2, 10'd3);
        s_move(2'h2, 2'h3, 2'h2, 10'd1);
        s_move(2'h3, 2'h3, 2'h0, 10'd0);
        wrap_up;
    end
endmodule // tb_top
